// [omm_mode_manager.sv]
`timescale 1ns/100ps
// Behaviour
// - test state only from default run or test
// - stopped clock in test locks until reset
// - test configurable except main regulator
// - run states from default, safe, run
// - interrupt wakes light sleep, interrupt or wakeup wakes deep sleep, to run
// - light sleep only from run state
// - light sleep aborted by active interrupt
// - deep sleep only from run state
// - deep sleep forces synthesizer off
// - sleep flash power limits per state
// - deep sleep aborted by interrupt or wakeup
// - leaving deep sleep runs from RC oscillator
// - invalid request ignored, target kept, flagged
// - hardware events load target field themselves
// - transition flag set at start
// - software reset forwarded, highest priority unless a safe event is pending
// - software safe request ranks second after reset
// - accepted request loads target configuration
// - flag held until status matches config
// - software safe overrides transition, no flag
module omm_mode_manager
    import omm_pkg::*;
(
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RESET,
    input  wire logic [ADDR_W-1:0] I_ADDR,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic              I_WR,
    input  wire logic              I_RD,
    output logic      [31:0]       O_RDATA,
    input  wire logic              I_SAFE_REQ,
    input  wire logic              I_IRQ_ACTIVE,
    input  wire logic              I_WAKEUP_ACTIVE,
    input  wire logic              I_IRC_STAT,
    input  wire logic              I_XOSC_STAT,
    input  wire logic              I_PLL_STAT,
    input  wire logic [1:0]        I_CFLA_STAT,
    input  wire logic [1:0]        I_DFLA_STAT,
    output logic                   O_TRANS,
    output logic      [3:0]        O_CUR_MODE,
    output logic                   O_IRC_ON,
    output logic                   O_XOSC_ON,
    output logic                   O_PLL_ON,
    output logic      [1:0]        O_CFLA_MODE,
    output logic      [1:0]        O_DFLA_MODE,
    output logic                   O_MAIN_REGULATOR_ON,
    output logic                   O_PDO,
    output logic      [3:0]        O_SYSTEM_CLOCK_SELECT_SEL,
    output logic                   O_SW_RESET_REQ,
    output logic                   O_INVALID_REQ
);

    // ********************************
    // helper functions
    // ********************************
    function automatic logic is_run(input logic [3:0] m);
        return (m >= MODE_RUN0) && (m <= MODE_RUN3);
    endfunction

    function automatic logic mode_ok(input logic [3:0] c, input logic [3:0] t);
        logic ok;
        ok = 1'b0;
        case (t)
            MODE_RESET: ok = (c == MODE_SAFE) || (c == MODE_DEFAULT_RUN_STATE) || is_run(c) || (c == MODE_TEST);
            MODE_TEST:  ok = (c == MODE_DEFAULT_RUN_STATE) || (c == MODE_TEST);
            MODE_SAFE:  ok = (c == MODE_DEFAULT_RUN_STATE) || is_run(c) ||
                             (c == MODE_TEST) || (c == MODE_SAFE);
            MODE_DEFAULT_RUN_STATE:  ok = is_run(c) || (c == MODE_SAFE) || (c == MODE_TEST) || (c == MODE_DEFAULT_RUN_STATE);
            MODE_HALT:  ok = is_run(c);
            MODE_STOP:  ok = is_run(c);
            default:    ok = is_run(t) &&
                             ((c == MODE_DEFAULT_RUN_STATE) || (c == MODE_SAFE) || is_run(c));
        endcase
        return ok;
    endfunction

    function automatic logic [19:0] cfg_rst(input logic [3:0] m);
        if (m == MODE_HALT) return CFG_RST_HALT;
        if (m == MODE_STOP) return CFG_RST_STOP;
        if (m == MODE_SAFE) return CFG_RST_SAFE;
        return CFG_RST_RUN;
    endfunction

    function automatic logic [19:0] cfg_wmask(input logic [3:0] m);
        if ((m == MODE_HALT) || (m == MODE_STOP)) return WMASK_SLEEP;
        if (m == MODE_TEST) return WMASK_TEST;
        if ((m == MODE_DEFAULT_RUN_STATE) || is_run(m)) return WMASK_RUN;
        if (m == MODE_SAFE) return WMASK_SAFE;
        return WMASK_NONE;
    endfunction

    // the configuration that really drives the resources of mode m
    function automatic logic [19:0] eff_cfg(input logic [19:0] c, input logic [3:0] m);
        logic [19:0] e;
        logic [3:0]  sc;
        e  = c;
        sc = c[CFG_SYSTEM_CLOCK_SELECT_LO +: 4];
        if (m == MODE_STOP) begin
            e[CFG_PLL] = 1'b0;
            if (e[CFG_CFLA_LO +: 2] == FLASH_LP) e[CFG_CFLA_LO +: 2] = FLASH_PD;
            if (e[CFG_DFLA_LO +: 2] == FLASH_LP) e[CFG_DFLA_LO +: 2] = FLASH_PD;
            if (sc == SYSTEM_CLOCK_SELECT_PLL) sc = SYSTEM_CLOCK_SELECT_IRC;
        end
        // a stopped clock is legal only in the test state
        if (!((sc == SYSTEM_CLOCK_SELECT_IRC) || (sc == SYSTEM_CLOCK_SELECT_XOSC) || (sc == SYSTEM_CLOCK_SELECT_PLL)) &&
            !((m == MODE_TEST) && (sc == SYSTEM_CLOCK_SELECT_OFF))) begin
            sc = SYSTEM_CLOCK_SELECT_IRC;
        end
        e[CFG_SYSTEM_CLOCK_SELECT_LO +: 4] = sc;
        return e;
    endfunction

    // ********************************
    // state
    // ********************************
    omm_state_t  st_r, st_nxt;
    logic [3:0]  cur_mode_r, cur_nxt;
    logic [3:0]  tgt_r, tgt_nxt;
    logic [3:0]  prev_run_r;
    logic [19:0] act_cfg_r;
    logic [3:0]  system_clock_select_r, system_clock_select_nxt;
    logic        trans_r, trans_nxt;
    logic        safe_lock_r, safe_lock_nxt;
    logic        swrst_r, swrst_nxt;
    logic        clk_lock_r;
    logic        armed_r;
    logic [3:0]  armed_tgt_r;
    logic        inv_flag_r;
    logic        inv_en_r;
    logic        inv_pulse_r;
    logic [31:0] rdata_r, rdata_nxt;
    logic [19:0] cfg_r [0:15];
    logic        ld;
    logic [3:0]  ld_mode;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);

    // ********************************
    // register bus decode
    // ********************************
    wire         wr_mctl  = I_WR && (I_ADDR == OFF_MCTL);
    wire         wr_ims   = I_WR && (I_ADDR == OFF_IMS);
    wire [7:0]   cfg_off  = I_ADDR - OFF_CFG_BASE;
    wire         cfg_hit  = (I_ADDR >= OFF_CFG_BASE) && (cfg_off[7:6] == 2'h0) &&
                            (I_ADDR[1:0] == 2'h0);
    wire [3:0]   cfg_idx  = cfg_off[5:2];
    wire         wr_cfg   = I_WR && cfg_hit;
    wire [15:0]  wr_key   = I_WDATA[MCTL_KEY_LO +: 16];
    wire [3:0]   wr_tgt   = I_WDATA[MCTL_TGT_LO +: 4];

    // ********************************
    // request qualification
    // ********************************
    wire key_one   = wr_mctl && (wr_key == KEY_FIRST);
    wire sw_req    = wr_mctl && (wr_key == KEY_SECOND) && armed_r &&
                     (wr_tgt == armed_tgt_r);
    wire bad_key   = wr_mctl && !key_one && !sw_req;
    wire sw_valid  = mode_ok(cur_mode_r, wr_tgt);
    // while a safe event is pending requests vanish silently; during a safe transition all but reset requests do
    wire quiet     = I_SAFE_REQ || safe_lock_r ||
                     (st_r == ST_SWRST) || (st_r == ST_RESET);
    wire blocked   = quiet || clk_lock_r;
    wire halt_abt  = (wr_tgt == MODE_HALT) && I_IRQ_ACTIVE;
    wire stop_abt  = (wr_tgt == MODE_STOP) && (I_IRQ_ACTIVE || I_WAKEUP_ACTIVE);
    wire sleep_abt = sw_req && sw_valid && (halt_abt || stop_abt);
    wire sw_rst    = sw_req && sw_valid && (wr_tgt == MODE_RESET) && !I_SAFE_REQ &&
                     !clk_lock_r && (st_r != ST_SWRST) && (st_r != ST_RESET);
    wire sw_go     = sw_req && sw_valid && (st_r == ST_IDLE) && !blocked && !sleep_abt;
    wire sw_safe   = sw_req && sw_valid && (wr_tgt == MODE_SAFE) && (st_r == ST_TRANS) &&
                     !blocked;
    wire sw_bad    = !blocked && (bad_key || (sw_req && (!sw_valid ||
                     ((st_r == ST_TRANS) && (wr_tgt != MODE_SAFE) && (wr_tgt != MODE_RESET)))));
    // with the clock stopped in the test state even a safe event cannot move the mode
    wire hw_safe   = I_SAFE_REQ && (tgt_r != MODE_SAFE) && !clk_lock_r &&
                     ((st_r == ST_IDLE) || (st_r == ST_TRANS));
    wire wake_ev   = (st_r == ST_IDLE) && !clk_lock_r &&
                     (((cur_mode_r == MODE_HALT) && I_IRQ_ACTIVE) ||
                      ((cur_mode_r == MODE_STOP) && (I_IRQ_ACTIVE || I_WAKEUP_ACTIVE)));
    wire fly_abt   = ((tgt_r == MODE_HALT) && I_IRQ_ACTIVE) ||
                     ((tgt_r == MODE_STOP) && (I_IRQ_ACTIVE || I_WAKEUP_ACTIVE));

    // ********************************
    // status match and clock source availability
    // ********************************
    wire [3:0] tgt_clk = act_cfg_r[CFG_SYSTEM_CLOCK_SELECT_LO +: 4];
    wire       src_ok  = (tgt_clk == SYSTEM_CLOCK_SELECT_OFF) || ((tgt_clk == SYSTEM_CLOCK_SELECT_IRC) && I_IRC_STAT) ||
                         ((tgt_clk == SYSTEM_CLOCK_SELECT_XOSC) && I_XOSC_STAT) ||
                         ((tgt_clk == SYSTEM_CLOCK_SELECT_PLL) && I_PLL_STAT);
    wire       match   = (I_IRC_STAT == act_cfg_r[CFG_IRC]) &&
                         (I_XOSC_STAT == act_cfg_r[CFG_XOSC]) &&
                         (I_PLL_STAT == act_cfg_r[CFG_PLL]) &&
                         (I_CFLA_STAT == act_cfg_r[CFG_CFLA_LO +: 2]) &&
                         (I_DFLA_STAT == act_cfg_r[CFG_DFLA_LO +: 2]) &&
                         (system_clock_select_r == tgt_clk);

    // ********************************
    // mode sequencing
    // ********************************
    always_comb begin
        st_nxt        = st_r;
        cur_nxt       = cur_mode_r;
        tgt_nxt       = tgt_r;
        trans_nxt     = trans_r;
        safe_lock_nxt = safe_lock_r;
        swrst_nxt     = swrst_r;
        ld            = 1'b0;
        ld_mode       = tgt_r;
        unique case (st_r)
            ST_RESET: begin
                ld      = 1'b1;
                ld_mode = MODE_DEFAULT_RUN_STATE;
            end
            ST_IDLE: begin
                if (sw_rst) begin
                    st_nxt    = ST_SWRST;
                    cur_nxt   = MODE_RESET;
                    tgt_nxt   = MODE_RESET;
                    swrst_nxt = 1'b1;
                end else if (hw_safe || (sw_go && (wr_tgt == MODE_SAFE))) begin
                    ld            = 1'b1;
                    ld_mode       = MODE_SAFE;
                    safe_lock_nxt = 1'b1;
                end else if (wake_ev) begin
                    ld      = 1'b1;
                    ld_mode = prev_run_r;
                end else if (sw_go) begin
                    ld      = 1'b1;
                    ld_mode = wr_tgt;
                end
            end
            ST_TRANS: begin
                if (sw_rst) begin
                    st_nxt    = ST_SWRST;
                    cur_nxt   = MODE_RESET;
                    tgt_nxt   = MODE_RESET;
                    trans_nxt = 1'b0;
                    swrst_nxt = 1'b1;
                end else if (hw_safe || sw_safe) begin
                    ld            = 1'b1;
                    ld_mode       = MODE_SAFE;
                    safe_lock_nxt = 1'b1;
                end else if (fly_abt) begin
                    ld      = 1'b1;
                    ld_mode = cur_mode_r;
                end else if (match) begin
                    st_nxt        = ST_IDLE;
                    cur_nxt       = tgt_r;
                    trans_nxt     = 1'b0;
                    safe_lock_nxt = 1'b0;
                end
            end
            ST_SWRST: begin
                // held here until the reset generation unit resets the whole device
                swrst_nxt = 1'b1;
            end
        endcase
        if (ld) begin
            tgt_nxt   = ld_mode;
            trans_nxt = 1'b1;
            st_nxt    = ST_TRANS;
        end
    end

    always_comb begin
        system_clock_select_nxt = system_clock_select_r;
        if (ld && (cur_mode_r == MODE_STOP)) begin
            system_clock_select_nxt = SYSTEM_CLOCK_SELECT_IRC;
        end else if (trans_r && (system_clock_select_r != tgt_clk) && src_ok) begin
            system_clock_select_nxt = tgt_clk;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            st_r        <= ST_RESET;
            cur_mode_r  <= MODE_RESET;
            tgt_r       <= MODE_RESET;
            trans_r     <= 1'b0;
            safe_lock_r <= 1'b0;
            swrst_r     <= 1'b0;
            system_clock_select_r    <= SYSTEM_CLOCK_SELECT_IRC;
        end else begin
            st_r        <= st_nxt;
            cur_mode_r  <= cur_nxt;
            tgt_r       <= tgt_nxt;
            trans_r     <= trans_nxt;
            safe_lock_r <= safe_lock_nxt;
            swrst_r     <= swrst_nxt;
            system_clock_select_r    <= system_clock_select_nxt;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            act_cfg_r  <= CFG_RST_RUN;
            prev_run_r <= MODE_RUN0;
            clk_lock_r <= 1'b0;
        end else begin
            if (ld) act_cfg_r <= eff_cfg(cfg_r[ld_mode], ld_mode);
            if (is_run(cur_nxt)) prev_run_r <= cur_nxt;
            // once the clock is gone nothing but a device reset can move the mode
            if ((cur_mode_r == MODE_TEST) && (system_clock_select_r == SYSTEM_CLOCK_SELECT_OFF)) clk_lock_r <= 1'b1;
        end
    end

    // ********************************
    // software-facing registers
    // ********************************
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            armed_r     <= 1'b0;
            armed_tgt_r <= MODE_RESET;
            inv_flag_r  <= 1'b0;
            inv_en_r    <= 1'b0;
            inv_pulse_r <= 1'b0;
            rdata_r     <= 32'h0000_0000;
        end else begin
            if (wr_mctl) armed_r <= key_one;
            if (key_one) armed_tgt_r <= wr_tgt;
            // a new invalid request wins over a clear in the same cycle
            inv_flag_r  <= sw_bad | (inv_flag_r & ~(wr_ims & I_WDATA[IMS_INV]));
            if (wr_ims) inv_en_r <= I_WDATA[IMS_EN];
            inv_pulse_r <= sw_bad && inv_en_r;
            rdata_r     <= rdata_nxt;
        end
    end

    for (genvar g = 0; g < 16; g++) begin : g_cfg
        always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
            if (I_RESET) begin
                cfg_r[g] <= cfg_rst(4'(g));
            end else if (wr_cfg && (cfg_idx == 4'(g))) begin
                cfg_r[g] <= (cfg_r[g] & ~cfg_wmask(4'(g))) |
                            (I_WDATA[CFG_W-1:0] & cfg_wmask(4'(g)));
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (I_RD) begin
            if (I_ADDR == OFF_MCTL) begin
                rdata_nxt[MCTL_TGT_LO +: 4] = tgt_r;
            end else if (I_ADDR == OFF_GS) begin
                rdata_nxt[GS_TRANS]          = trans_r;
                rdata_nxt[GS_MODE_LO +: 4]   = cur_mode_r;
                rdata_nxt[GS_SYSTEM_CLOCK_SELECT_LO +: 4] = system_clock_select_r;
                rdata_nxt[GS_IRC]            = I_IRC_STAT;
                rdata_nxt[GS_XOSC]           = I_XOSC_STAT;
                rdata_nxt[GS_PLL]            = I_PLL_STAT;
                rdata_nxt[GS_CFLA_LO +: 2]   = I_CFLA_STAT;
                rdata_nxt[GS_DFLA_LO +: 2]   = I_DFLA_STAT;
            end else if (I_ADDR == OFF_IMS) begin
                rdata_nxt[IMS_INV] = inv_flag_r;
                rdata_nxt[IMS_EN]  = inv_en_r;
            end else if (cfg_hit) begin
                rdata_nxt[CFG_W-1:0] = cfg_r[cfg_idx];
            end
        end
    end

    assign O_RDATA        = rdata_r;
    assign O_TRANS        = trans_r;
    assign O_CUR_MODE     = cur_mode_r;
    assign O_IRC_ON       = act_cfg_r[CFG_IRC];
    assign O_XOSC_ON      = act_cfg_r[CFG_XOSC];
    assign O_PLL_ON       = act_cfg_r[CFG_PLL];
    assign O_CFLA_MODE    = act_cfg_r[CFG_CFLA_LO +: 2];
    assign O_DFLA_MODE    = act_cfg_r[CFG_DFLA_LO +: 2];
    assign O_MAIN_REGULATOR_ON     = act_cfg_r[CFG_MAIN_REGULATOR];
    assign O_PDO          = act_cfg_r[CFG_PDO];
    assign O_SYSTEM_CLOCK_SELECT_SEL   = system_clock_select_r;
    assign O_SW_RESET_REQ = swrst_r;
    assign O_INVALID_REQ  = inv_pulse_r;

    // ********************************
    // assertions
    // ********************************
    test_entry_a: assert property (sw_go && (wr_tgt == MODE_TEST) |->
        ((cur_mode_r == MODE_DEFAULT_RUN_STATE) || (cur_mode_r == MODE_TEST)) ##1
        (tgt_r == MODE_TEST) && O_TRANS)
        else $error("test state entered from a state other than default run");
    clock_lock_a: assert property (clk_lock_r |=>
        clk_lock_r && (O_CUR_MODE == MODE_TEST) && !O_SW_RESET_REQ)
        else $error("test state left while the system clock was stopped");
    test_regulator_a: assert property ((tgt_r == MODE_TEST) && O_TRANS |-> O_MAIN_REGULATOR_ON)
        else $error("main regulator off in the test state");
    run_entry_a: assert property (sw_go && is_run(wr_tgt) |=>
        (tgt_r == $past(I_WDATA[31:28])) && O_TRANS)
        else $error("application run request not loaded into the target field");
    sleep_wake_a: assert property ((st_r == ST_IDLE) && (cur_mode_r == MODE_HALT) &&
        I_IRQ_ACTIVE && !I_SAFE_REQ && !sw_rst |=> O_TRANS && (tgt_r == $past(prev_run_r)))
        else $error("interrupt did not wake light sleep");
    halt_abort_a: assert property (sleep_abt && (st_r == ST_IDLE) |=>
        !O_INVALID_REQ && $stable(inv_flag_r) && (tgt_r != MODE_HALT) && (tgt_r != MODE_STOP))
        else $error("aborted sleep request started a transition or flagged invalid");
    stop_pll_a: assert property (O_TRANS && (tgt_r == MODE_STOP) |-> !O_PLL_ON &&
        (O_CFLA_MODE != FLASH_LP))
        else $error("synthesizer on or flash low-power toward deep sleep");
    stop_exit_clk_a: assert property (wake_ev && (cur_mode_r == MODE_STOP) && !hw_safe &&
        !sw_rst |=> (O_SYSTEM_CLOCK_SELECT_SEL == SYSTEM_CLOCK_SELECT_IRC) && O_TRANS)
        else $error("deep sleep exit not on the RC oscillator");
    invalid_keep_a: assert property (sw_bad && (st_r == ST_IDLE) && !wake_ev |=>
        $stable(tgt_r) && inv_flag_r && (O_INVALID_REQ == $past(inv_en_r)))
        else $error("invalid request changed the target or went unflagged");
    done_update_a: assert property ($fell(O_TRANS) && (O_CUR_MODE != MODE_RESET) |->
        (O_CUR_MODE == tgt_r) && $past(match))
        else $error("transition ended without status match or mode update");
    safe_final_a: assert property (sw_safe && !sw_rst |=> (tgt_r == MODE_SAFE) && O_TRANS
        ##1 (tgt_r == MODE_SAFE))
        else $error("safe request did not become the final target");
    swrst_a: assert property (sw_rst |=> O_SW_RESET_REQ [*2])
        else $error("software reset request not forwarded");

    halt_done_c: cover property ((tgt_r == MODE_HALT) && O_TRANS ##[1:20]
        (O_CUR_MODE == MODE_HALT));
    stop_wake_c: cover property ((O_CUR_MODE == MODE_STOP) ##[1:20] wake_ev);
    safe_ovr_c:  cover property (sw_safe);
    test_lock_c: cover property ($rose(clk_lock_r));

endmodule

// [omm_pkg.sv]
package omm_pkg;

    // ********************************
    // mode codes of the requested-state field
    // ********************************
    localparam logic [3:0]  MODE_RESET = 4'h0;
    localparam logic [3:0]  MODE_TEST  = 4'h1;
    localparam logic [3:0]  MODE_SAFE  = 4'h2;
    localparam logic [3:0]  MODE_DEFAULT_RUN_STATE  = 4'h3;
    localparam logic [3:0]  MODE_RUN0  = 4'h4;
    localparam logic [3:0]  MODE_RUN3  = 4'h7;
    localparam logic [3:0]  MODE_HALT  = 4'h8;
    localparam logic [3:0]  MODE_STOP  = 4'hA;

    localparam logic [15:0] KEY_FIRST  = 16'h5AF0;
    localparam logic [15:0] KEY_SECOND = 16'hA50F;

    // ********************************
    // register map and field positions
    // ********************************
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFF_MCTL     = 8'h00;
    localparam logic [7:0]  OFF_GS       = 8'h04;
    localparam logic [7:0]  OFF_IMS      = 8'h08;
    localparam logic [7:0]  OFF_CFG_BASE = 8'h20;
    localparam int          MCTL_KEY_LO  = 0;
    localparam int          MCTL_TGT_LO  = 28;
    localparam int          GS_TRANS     = 0;
    localparam int          GS_MODE_LO   = 4;
    localparam int          GS_SYSTEM_CLOCK_SELECT_LO = 8;
    localparam int          GS_IRC       = 12;
    localparam int          GS_XOSC      = 13;
    localparam int          GS_PLL       = 14;
    localparam int          GS_CFLA_LO   = 16;
    localparam int          GS_DFLA_LO   = 18;
    localparam int          IMS_INV      = 0;
    localparam int          IMS_EN       = 1;

    localparam int          CFG_W        = 20;
    localparam int          CFG_IRC      = 0;
    localparam int          CFG_XOSC     = 1;
    localparam int          CFG_PLL      = 2;
    localparam int          CFG_CFLA_LO  = 4;
    localparam int          CFG_DFLA_LO  = 6;
    localparam int          CFG_MAIN_REGULATOR    = 8;
    localparam int          CFG_PDO      = 9;
    localparam int          CFG_SYSTEM_CLOCK_SELECT_LO = 16;

    localparam logic [1:0]  FLASH_PD   = 2'h0;
    localparam logic [1:0]  FLASH_LP   = 2'h1;
    localparam logic [1:0]  FLASH_NORM = 2'h3;

    localparam logic [3:0]  SYSTEM_CLOCK_SELECT_IRC  = 4'h0;
    localparam logic [3:0]  SYSTEM_CLOCK_SELECT_XOSC = 4'h1;
    localparam logic [3:0]  SYSTEM_CLOCK_SELECT_PLL  = 4'h2;
    localparam logic [3:0]  SYSTEM_CLOCK_SELECT_OFF  = 4'hF;

    // ********************************
    // reset values and write masks of the mode configurations
    // ********************************
    localparam logic [19:0] CFG_RST_RUN  = 20'h001F1;
    localparam logic [19:0] CFG_RST_HALT = 20'h00151;
    localparam logic [19:0] CFG_RST_STOP = 20'h00101;
    localparam logic [19:0] CFG_RST_SAFE = 20'h003F1;
    localparam logic [19:0] WMASK_SLEEP  = 20'hF03F7;
    localparam logic [19:0] WMASK_TEST   = 20'hF02F7;
    localparam logic [19:0] WMASK_RUN    = 20'hF02F6;
    localparam logic [19:0] WMASK_SAFE   = 20'h00200;
    localparam logic [19:0] WMASK_NONE   = 20'h00000;

    typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_TRANS, ST_SWRST} omm_state_t;

endpackage

// [omm_src_model.sv]
`timescale 1ns/100ps
module omm_src_model (
    input  wire logic       i_clk,
    input  wire logic [6:0] i_on,
    output logic      [6:0] o_stat
);
    logic [6:0] d1_r;
    // sources and flashes settle two cycles after a change, so the flag is seen held
    always @(posedge i_clk) begin
        d1_r   <= i_on;
        o_stat <= d1_r;
    end
endmodule

// [operating_mode_manager_tb.sv]
`timescale 1ns/100ps
module operating_mode_manager_tb;
    import omm_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic        safe = 1'b0, irq = 1'b0, wake = 1'b0, trans, pad_outputs_off, swr;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    wire  [6:0]  on, stat;
    wire  [3:0]  cur, sclk;
    wire         inv, mvr;
    logic [3:0]  m;
    logic [31:0] exp_q[$];
    int          err_total = 0, checks = 0;
    always #10 clk = ~clk;
    omm_mode_manager i_omm_mode_manager (.I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SAFE_REQ(safe),
        .I_IRQ_ACTIVE(irq), .I_WAKEUP_ACTIVE(wake), .I_IRC_STAT(stat[0]),
        .I_XOSC_STAT(stat[1]), .I_PLL_STAT(stat[2]), .I_CFLA_STAT(stat[4:3]),
        .I_DFLA_STAT(stat[6:5]), .O_TRANS(trans), .O_CUR_MODE(cur), .O_IRC_ON(on[0]),
        .O_XOSC_ON(on[1]), .O_PLL_ON(on[2]), .O_CFLA_MODE(on[4:3]), .O_DFLA_MODE(on[6:5]),
        .O_MAIN_REGULATOR_ON(mvr), .O_PDO(pad_outputs_off), .O_SYSTEM_CLOCK_SELECT_SEL(sclk), .O_SW_RESET_REQ(swr),
        .O_INVALID_REQ(inv));
    omm_src_model i_omm_src_model (.i_clk(clk), .i_on(on), .o_stat(stat));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd32(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a; exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // key then inverted key, the only sequence software may use
    task automatic req(input logic [3:0] t);
        wr32(OFF_MCTL, {t, 12'h0, KEY_FIRST});
        wr32(OFF_MCTL, {t, 12'h0, KEY_SECOND});
        #1;
    endtask
    task automatic settle(input logic [3:0] md, input logic [3:0] fl);
        int i;
        for (i = 0; i < 300 && !(i > 2 && trans === 1'b0); i++) @(posedge clk);
        if (i == 300) begin
            err_total++;
            close_out();
        end else begin
            rd32(OFF_GS, {12'h0, fl, 4'h1, 4'h0, md, 4'h0});
        end
    endtask
    // read data is judged in the only cycle it stands
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) check(rdata, exp_q.pop_front());
    end
    initial begin
        m = 4'(4 + $urandom(68768) % 4);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        settle(MODE_DEFAULT_RUN_STATE, 4'hF);
        req(m);
        check(trans, 1'b1);
        settle(m, 4'hF);
        check(cur, m);
        wr32(OFF_IMS, 32'h2);
        req(MODE_TEST);
        check(inv, 1'b1);
        rd32(OFF_IMS, 32'h3);
        rd32(OFF_MCTL, {m, 28'h0});
        $display("test done: run entry and refusal");
        wr32(OFF_IMS, 32'h3);
        irq <= 1'b1;
        req(MODE_HALT);
        settle(m, 4'hF);
        rd32(OFF_IMS, 32'h2);
        irq <= 1'b0;
        req(MODE_HALT);
        settle(MODE_HALT, 4'h5);
        irq <= 1'b1;
        settle(m, 4'hF);
        rd32(OFF_MCTL, {m, 28'h0});
        irq <= 1'b0;
        $display("test done: light sleep");
        wake <= 1'b1;
        req(MODE_STOP);
        settle(m, 4'hF);
        wake <= 1'b0;
        req(MODE_STOP);
        settle(MODE_STOP, 4'h0);
        wake <= 1'b1;
        settle(m, 4'hF);
        check(sclk, SYSTEM_CLOCK_SELECT_IRC);
        wake <= 1'b0;
        $display("test done: deep sleep");
        safe <= 1'b1;
        settle(MODE_SAFE, 4'hF);
        check(pad_outputs_off, 1'b1);
        check(mvr, 1'b1);
        safe <= 1'b0;
        req(MODE_DEFAULT_RUN_STATE);
        settle(MODE_DEFAULT_RUN_STATE, 4'hF);
        req(MODE_RESET);
        @(posedge clk);
        #1;
        check(swr, 1'b1);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check(swr, 1'b0);
        rst <= 1'b0;
        settle(MODE_DEFAULT_RUN_STATE, 4'hF);
        $display("test done: safe and reset");
        close_out();
    end
endmodule
